// file: fgr_pkg.sv
// Constants and types for the fine granularity refresh rate logic.
// Assumes a 50 MHz core clock; command pins arrive from the controller.
// Refresh rate rules for this block and its controller
// R1: Mode field decodes fixed or on-the-fly rates
// R2: Controller programs on-the-fly before using it
// R3: On-the-fly mode: bank group bit picks rate
// R4: Refresh decoded from select and strobe levels
// R5: Controller spaces refreshes by rate interval
// R6: Controller waits rate-specific refresh cycle time
// R7: Fixed modes allow only their own rate
// R8: On-the-fly modes allow single or fast rate
// R9: New rate timing applies from change
// R10: Even double-rate count before mode change
// R11: Even double-rate count between single refreshes
// R12: Quad count multiple of four before change
// R13: Quad count multiple of four between singles
// R14: Same-rate fixed/on-the-fly switch is no change
// R15: Temperature refresh needs fixed single-rate mode
// R16: Self refresh entry accepted in any mode
// R17: Odd double count owes extra refreshes
// R18: Quad count not multiple owes extra refreshes
// R19: Extra refreshes excluded from interval average
// R20: Extra refreshes tracked apart from postponement
// R21: Postpone limit eight, sixteen, thirty-two
// R22: Only deselects during refresh cycle time
// R23: Controller counts fast refreshes per rank
package fgr_pkg;

  // Mode field encodings
  localparam logic [2:0] FGR_MODE_FIX1X  = 3'h0;
  localparam logic [2:0] FGR_MODE_FIX2X  = 3'h1;
  localparam logic [2:0] FGR_MODE_FIX4X  = 3'h2;
  localparam logic [2:0] FGR_MODE_OTF12  = 3'h5;
  localparam logic [2:0] FGR_MODE_OTF14  = 3'h6;

  // Position of the mode field in the mode register word
  localparam int FGR_MODE_LSB = 6;

  // Refresh cycle times and clock period in ns
  localparam int FGR_TRFC1_NS = 350;
  localparam int FGR_TRFC2_NS = 260;
  localparam int FGR_TRFC4_NS = 160;
  localparam int FGR_CLK_NS   = 20;

  // Minimum times round up to whole cycles
  localparam int FGR_TRFC1_CYC = (FGR_TRFC1_NS + FGR_CLK_NS - 1) / FGR_CLK_NS;
  localparam int FGR_TRFC2_CYC = (FGR_TRFC2_NS + FGR_CLK_NS - 1) / FGR_CLK_NS;
  localparam int FGR_TRFC4_CYC = (FGR_TRFC4_NS + FGR_CLK_NS - 1) / FGR_CLK_NS;

  // Width of the busy counter
  localparam int FGR_CNT_W = 5;

  // Base refresh interval in ns (7.8 us)
  localparam int FGR_TREFI_BASE_NS = 7800;

  // Refresh rate of an operation
  typedef enum logic [1:0] {
    FGR_RATE_1X,
    FGR_RATE_2X,
    FGR_RATE_4X
  } fgr_rate_t;

endpackage : fgr_pkg

// file: fgr_cmd_decode.sv
// Command decoder for refresh, mode write and self refresh.
// Assumes the command pins are already synchronised to ref_clk_i.
`timescale 1ns/10ps
module fgr_cmd_decode
  import fgr_pkg::*;
(
  input  wire logic cs_n_i,    // Chip select, active low
  input  wire logic act_n_i,   // Activate, active low
  input  wire logic ras_n_i,   // Row strobe / A16
  input  wire logic cas_n_i,   // Column strobe / A15
  input  wire logic we_n_i,    // Write enable / A14
  input  wire logic cke_i,     // Clock enable level
  input  wire logic cke_q_i,   // Clock enable, last cycle
  output logic      ref_o,     // Refresh decoded
  output logic      mrs_o,     // Mode register write decoded
  output logic      sre_o,     // Self refresh entry decoded
  output logic      srx_o      // Self refresh exit decoded
);

  // Pure decode; registered in the parent
  always_comb begin
    // R4: refresh pattern
    ref_o = !cs_n_i && act_n_i && !ras_n_i && !cas_n_i && we_n_i && cke_i;
    mrs_o = !cs_n_i && act_n_i && !ras_n_i && !cas_n_i && !we_n_i;
    sre_o = !cs_n_i && act_n_i && !ras_n_i && !cas_n_i && we_n_i &&
            cke_q_i && !cke_i;
    // Exit is clock enable rising with deselect
    srx_o = cke_i && !cke_q_i && cs_n_i;
  end

endmodule : fgr_cmd_decode

// file: fgr_refresh_rate.sv
// Refresh rate selection core: holds the mode field, picks the rate
// of each refresh, times the refresh cycle and reports the extra
// refreshes owed after self refresh exit.
// Assumes pins from the controller; mode write of the refresh field
// is decoded from the pins as cmd_mrs with bank address selecting register three.
`timescale 1ns/10ps
module fgr_refresh_rate
  import fgr_pkg::*;
(
  input  wire logic        ref_clk_i,       // Core clock, 50 MHz
  input  wire logic        reset_i,         // Async reset, active high
  input  wire logic        cs_n_i,          // Chip select pin
  input  wire logic        act_n_i,         // Activate pin
  input  wire logic        ras_n_i,         // RAS/A16 pin
  input  wire logic        cas_n_i,         // CAS/A15 pin
  input  wire logic        we_n_i,          // WE/A14 pin
  input  wire logic        cke_i,           // Clock enable pin
  input  wire logic        bg0_i,           // Bank group 0 pin
  input  wire logic [1:0]  ba_i,            // Bank address pins
  input  wire logic [13:0] addr_i,          // Address pins A13..A0
  input  wire logic        temp_refresh_i,  // Temp refresh enabled
  output logic [2:0]       fine_grain_refresh_mode_o, // Mode field
  output logic             refresh_busy_o,  // Refresh cycle running
  output logic [1:0]       refresh_rate_o,  // Rate of last refresh
  output logic             extra_refresh_owed_o, // Owed after exit
  output logic             self_refresh_o,  // In self refresh
  output logic             mode_illegal_o   // Reserved/bad combo
);

  // Two-stage synchronisers for all pins but A0
  localparam int PIN_W = 22;
  logic [PIN_W-1:0] pin_raw;      // Raw pin vector
  logic [PIN_W-1:0] pin_meta_ff;  // First stage, read by second only
  logic [PIN_W-1:0] pin_sync_ff;  // Second stage
  logic             cke_q_ff;     // Clock enable one cycle later
  // A0 is never used, so only A13..A1 are carried
  assign pin_raw = {cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, cke_i,
                    bg0_i, ba_i, addr_i[13:1]};

  // Temperature refresh level, synchronised like the pins
  logic temp_meta_ff;  // First stage
  logic temp_sync_ff;  // Second stage, the only one read

  // Synchroniser registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta_ff  <= '1;
      pin_sync_ff  <= '1;
      // Matches the idle high level, so no false exit after reset
      cke_q_ff     <= 1'b1;
      temp_meta_ff <= 1'b0;
      temp_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff  <= pin_raw;
      pin_sync_ff  <= pin_meta_ff;
      cke_q_ff     <= pin_sync_ff[16];
      temp_meta_ff <= temp_refresh_i;
      temp_sync_ff <= temp_meta_ff;
    end
  end

  // Named views of synchronised pins
  logic        s_cs_n, s_act_n, s_ras_n, s_cas_n, s_we_n, s_cke, s_bg0;
  logic [1:0]  s_ba;
  logic [12:0] s_addr;  // A13..A1
  assign s_cs_n  = pin_sync_ff[21];
  assign s_act_n = pin_sync_ff[20];
  assign s_ras_n = pin_sync_ff[19];
  assign s_cas_n = pin_sync_ff[18];
  assign s_we_n  = pin_sync_ff[17];
  assign s_cke   = pin_sync_ff[16];
  assign s_bg0   = pin_sync_ff[15];
  assign s_ba    = pin_sync_ff[14:13];
  assign s_addr  = pin_sync_ff[12:0];

  // Decoded commands
  logic cmd_ref, cmd_mrs, cmd_sre, cmd_srx;
  fgr_cmd_decode u_dec (
    .cs_n_i  (s_cs_n),
    .act_n_i (s_act_n),
    .ras_n_i (s_ras_n),
    .cas_n_i (s_cas_n),
    .we_n_i  (s_we_n),
    .cke_i   (s_cke),
    .cke_q_i (cke_q_ff),
    .ref_o   (cmd_ref),
    .mrs_o   (cmd_mrs),
    .sre_o   (cmd_sre),
    .srx_o   (cmd_srx)
  );

  // State of the rate logic
  logic [2:0]           mode_ff,   nxt_mode;
  logic [FGR_CNT_W-1:0] busy_ff,   nxt_busy;
  fgr_rate_t            rate_ff,   nxt_rate;
  logic [1:0]           fast_ff,   nxt_fast;  // Fast refreshes mod 4
  logic                 owed_ff,   nxt_owed;
  logic                 sr_ff,     nxt_sr;
  logic                 ill_ff,    nxt_ill;
  logic [2:0]           new_mode;  // Field from a mode write
  fgr_rate_t            ref_rate;  // Rate chosen for this refresh
  fgr_rate_t            mode_rate; // Fast rate implied by a mode

  assign new_mode = s_addr[FGR_MODE_LSB+2-1:FGR_MODE_LSB-1];

  // Fast rate of a mode field
  function automatic fgr_rate_t rate_of(input logic [2:0] m);
    fgr_rate_t r;
    r = FGR_RATE_1X;
    // R1: field decode
    case (m)
      FGR_MODE_FIX2X, FGR_MODE_OTF12: r = FGR_RATE_2X;
      FGR_MODE_FIX4X, FGR_MODE_OTF14: r = FGR_RATE_4X;
      default:                        r = FGR_RATE_1X;
    endcase
    return r;
  endfunction : rate_of

  // Next-state logic
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_busy  = busy_ff;
    nxt_rate  = rate_ff;
    nxt_fast  = fast_ff;
    nxt_owed  = owed_ff;
    nxt_sr    = sr_ff;
    mode_rate = rate_of(mode_ff);
    ref_rate  = mode_rate;
    // R3: bank group bit picks rate in on-the-fly
    if (mode_ff[2]) begin
      ref_rate = s_bg0 ? mode_rate : FGR_RATE_1X;
    end
    // Busy countdown
    if (busy_ff != '0) begin
      nxt_busy = busy_ff - 1'b1;
    end
    if (cmd_mrs && s_ba == 2'h3) begin
      nxt_mode = new_mode;
      // R14: same-rate switch keeps the fast count
      if (rate_of(new_mode) != mode_rate) begin
        nxt_fast = '0;
      end
    end else if (cmd_ref && !sr_ff) begin
      // R9: new cycle time from this refresh
      nxt_rate = ref_rate;
      // R6: cycle time by rate
      case (ref_rate)
        FGR_RATE_2X: nxt_busy = FGR_CNT_W'(FGR_TRFC2_CYC);
        FGR_RATE_4X: nxt_busy = FGR_CNT_W'(FGR_TRFC4_CYC);
        default:     nxt_busy = FGR_CNT_W'(FGR_TRFC1_CYC);
      endcase
      // R23: fast count, cleared by single rate
      if (ref_rate == FGR_RATE_1X) begin
        nxt_fast = '0;
        nxt_owed = 1'b0;
      end else begin
        nxt_fast = fast_ff + 1'b1;
      end
      // Owed extras paid by completing the group
      if (owed_ff && ref_rate != FGR_RATE_1X) begin
        nxt_owed = (ref_rate == FGR_RATE_2X) ? (fast_ff[0] == 1'b0)
                                             : (fast_ff != 2'h3);
      end
    end else if (cmd_sre) begin
      // R16: entry accepted in any mode
      nxt_sr = 1'b1;
      // R17: odd double count owes extras
      // R18: quad count not a multiple owes extras
      if (mode_rate == FGR_RATE_2X) begin
        nxt_owed = fast_ff[0];
      end else if (mode_rate == FGR_RATE_4X) begin
        nxt_owed = (fast_ff != 2'h0);
      end
    end else if (cmd_srx) begin
      nxt_sr   = 1'b0;
      nxt_fast = '0;
    end
    // R15: reserved code or temperature refresh conflict
    nxt_ill = (nxt_mode == 3'h3) || (nxt_mode == 3'h4) ||
              (nxt_mode == 3'h7) ||
              (temp_sync_ff && nxt_mode != FGR_MODE_FIX1X);
  end

  // State registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_ff <= FGR_MODE_FIX1X;
      busy_ff <= '0;
      rate_ff <= FGR_RATE_1X;
      fast_ff <= '0;
      owed_ff <= 1'b0;
      sr_ff   <= 1'b0;
      ill_ff  <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      busy_ff <= nxt_busy;
      rate_ff <= nxt_rate;
      fast_ff <= nxt_fast;
      owed_ff <= nxt_owed;
      sr_ff   <= nxt_sr;
      ill_ff  <= nxt_ill;
    end
  end

  // Outputs come from registers
  logic busy_out_ff;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_out_ff <= 1'b0;
    end else begin
      busy_out_ff <= (nxt_busy != '0);
    end
  end

  assign fine_grain_refresh_mode_o = mode_ff;
  assign refresh_busy_o            = busy_out_ff;
  assign refresh_rate_o            = rate_ff;
  assign extra_refresh_owed_o      = owed_ff;
  assign self_refresh_o            = sr_ff;
  assign mode_illegal_o            = ill_ff;

endmodule : fgr_refresh_rate

// file: fgr_refresh_rate_asserts.sv
// Checker for the refresh rate core, bound to its ports.
// Assumes one clock and three edges from pins to state.
`timescale 1ns/10ps
module fgr_refresh_rate_chk
  import fgr_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        cs_n_i,
  input wire logic        ras_n_i,
  input wire logic        cas_n_i,
  input wire logic        we_n_i,
  input wire logic        cke_i,
  input wire logic        bg0_i,
  input wire logic [1:0]  ba_i,
  input wire logic [13:0] addr_i,
  input wire logic        temp_refresh_i,
  input wire logic [2:0]  fine_grain_refresh_mode_o,
  input wire logic        refresh_busy_o,
  input wire logic [1:0]  refresh_rate_o,
  input wire logic        self_refresh_o,
  input wire logic        mode_illegal_o
);
  logic [4:0] len_ff;  // Busy cycles counted
  logic [4:0] nxt_len;
  logic       ref_pin; // Refresh pattern seen
  logic       mrs_pin; // Mode write pattern seen
  always_comb nxt_len = refresh_busy_o ? len_ff + 5'h1 : 5'h0;
  // Length counter, long counts kept out of repetitions
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) len_ff <= 5'h0;
    else len_ff <= nxt_len;
  end
  assign ref_pin = !cs_n_i && !ras_n_i && !cas_n_i && we_n_i && cke_i;
  assign mrs_pin = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i
                   && ba_i == 2'h3 && !self_refresh_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_ref_go;
    ref_pin && !refresh_busy_o && !self_refresh_o;
  endsequence
  AST_REF_BUSY: assert property (s_ref_go |-> ##3 refresh_busy_o)
    else $error("refresh did not start");
  AST_MODE: assert property (mrs_pin |-> ##3
    fine_grain_refresh_mode_o == $past(addr_i[8:6], 3))
    else $error("mode field not taken");
  AST_RESV: assert property (fine_grain_refresh_mode_o inside
    {3'h3, 3'h4, 3'h7} |-> ##[0:1] mode_illegal_o)
    else $error("reserved code not flagged");
  AST_TEMP: assert property ((temp_refresh_i
    && fine_grain_refresh_mode_o != 3'h0)[*4] |-> mode_illegal_o)
    else $error("temperature conflict not flagged");
  AST_FIX: assert property ($rose(refresh_busy_o)
    && fine_grain_refresh_mode_o < 3'h3
    |-> refresh_rate_o == fine_grain_refresh_mode_o[1:0])
    else $error("fixed mode rate wrong");
  AST_OTF: assert property (s_ref_go ##0 fine_grain_refresh_mode_o[2]
    |-> ##3 refresh_rate_o == ($past(bg0_i, 3) ?
    2'h2 - {1'b0, fine_grain_refresh_mode_o[0]} : 2'h0))
    else $error("on-the-fly rate wrong");
  AST_TRFC: assert property ($fell(refresh_busy_o) |-> len_ff ==
    (refresh_rate_o == 2'h0 ? 5'(FGR_TRFC1_CYC) :
     refresh_rate_o == 2'h1 ? 5'(FGR_TRFC2_CYC) : 5'(FGR_TRFC4_CYC)))
    else $error("cycle time length wrong");
  AST_SRE: assert property ($past(cke_i) && !cke_i && !cs_n_i
    && !ras_n_i && !cas_n_i && we_n_i && !self_refresh_o
    |-> ##3 self_refresh_o)
    else $error("self refresh entry refused");
endmodule : fgr_refresh_rate_chk
bind fgr_refresh_rate fgr_refresh_rate_chk u_chk (.*);

// file: fgr_ctrl_model.sv
// Controller model driving the command pins of the core.
// Assumes the bench calls send; pins change on falling edges.
`timescale 1ns/10ps
module fgr_ctrl_model (
  input  wire logic        ref_clk_i,
  output logic             cs_n_o,
  output logic             ras_n_o,
  output logic             cas_n_o,
  output logic             we_n_o,
  output logic             cke_o,
  output logic             bg0_o,
  output logic [1:0]       ba_o,
  output logic [13:0]      addr_o
);
  // Idle deselect, clock enabled
  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, cke_o, bg0_o} = 6'h3f;
    ba_o   = 2'h0;
    addr_o = 14'h0;
  end
  task automatic send(input logic [3:0] c, input logic k,
                      input logic b, input logic [1:0] a2,
                      input logic [13:0] a);
    @(negedge ref_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
    cke_o  = k;
    bg0_o  = b;
    ba_o   = a2;
    addr_o = a;
    @(negedge ref_clk_i);
    // Released lines show no stale value
    cs_n_o = 1'b1;
    bg0_o  = ~b;
    addr_o = ~a;
  endtask : send
endmodule : fgr_ctrl_model

// file: fine_granularity_refresh_mode_tb.sv
// Self-checking bench for the refresh rate core.
// Assumes three edges of latency and busy lengths from the package.
`timescale 1ns/10ps
module fine_granularity_refresh_mode_tb;
  import fgr_pkg::*;
  logic        clk = 1'b0;
  logic        reset_i = 1'b1;
  logic        temp_i = 1'b0;
  logic        cs_n, ras_n, cas_n, we_n, cke, bg0, busy, owed, sr, ill;
  logic [1:0]  ba, rate;
  logic [2:0]  mode;
  logic [13:0] addr;
  logic [31:0] rnd = 32'h43; // Xorshift state
  logic [31:0] x;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int mode_m = 0; // Model mode field
  int cnt_m = 0;  // Model fast refresh count
  int owed_m = 0; // Model owed flag
  always #10 clk = ~clk;
  fgr_ctrl_model u_fgr_ctrl_model (.ref_clk_i(clk), .cs_n_o(cs_n),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .cke_o(cke),
    .bg0_o(bg0), .ba_o(ba), .addr_o(addr));
  fgr_refresh_rate u_fgr_refresh_rate (.ref_clk_i(clk), .reset_i(reset_i),
    .cs_n_i(cs_n), .act_n_i(1'b1), .ras_n_i(ras_n), .cas_n_i(cas_n),
    .we_n_i(we_n), .cke_i(cke), .bg0_i(bg0), .ba_i(ba), .addr_i(addr),
    .temp_refresh_i(temp_i), .fine_grain_refresh_mode_o(mode),
    .refresh_busy_o(busy), .refresh_rate_o(rate),
    .extra_refresh_owed_o(owed), .self_refresh_o(sr),
    .mode_illegal_o(ill));
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  task automatic chk(input logic [7:0] got, input int exp);
    comparisons++;
    if (got !== 8'(exp)) begin
      miscompares++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic mrs(input int m);
    x = xs();
    u_fgr_ctrl_model.send(4'h0, 1'b1, x[0], 2'h3, {x[9:5], 3'(m), x[5:0]});
    if ((m % 4 % 3) != (mode_m % 4 % 3)) cnt_m = 0;
    mode_m = m;
    repeat (4) @(negedge clk);
    chk(8'(mode), m);
    chk(8'(ill), m inside {3, 4, 7} || (temp_i && m != 0));
  endtask : mrs
  task automatic refr(input logic b);
    int r;
    int n;
    int e;
    r = mode_m[2] ? (b ? (mode_m == 5 ? 1 : 2) : 0) : mode_m[1:0];
    e = r == 0 ? FGR_TRFC1_CYC : r == 1 ? FGR_TRFC2_CYC : FGR_TRFC4_CYC;
    x = xs();
    u_fgr_ctrl_model.send(4'h1, 1'b1, b, x[1:0], x[13:0]);
    if (r == 0) cnt_m = 0;
    else cnt_m++;
    if (r == 0 || cnt_m % (r == 1 ? 2 : 4) == 0) owed_m = 0;
    // Rate is visible from the third falling edge on
    repeat (2) @(negedge clk);
    chk(8'(rate), r);
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk(8'(n), e);
    chk(8'(owed), owed_m);
    repeat ((FGR_TREFI_BASE_NS / FGR_CLK_NS >> r) - n - 5) @(negedge clk);
  endtask : refr
  task automatic srf();
    int md;
    md = (mode_m % 4 == 1) ? 2 : (mode_m % 4 == 2) ? 4 : 1;
    u_fgr_ctrl_model.send(4'h1, 1'b0, 1'b0, 2'h0, 14'h0);
    repeat (3) @(negedge clk);
    chk(8'(sr), 1);
    u_fgr_ctrl_model.send(4'hf, 1'b1, 1'b0, 2'h0, 14'h0);
    owed_m = (cnt_m % md != 0);
    cnt_m = 0;
    repeat (3) @(negedge clk);
    chk(8'(sr), 0);
    chk(8'(owed), owed_m);
  endtask : srf
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_i = 1'b0;
    chk({2'h0, mode, busy, owed, ill}, 0);
    for (int m = 0; m < 8; m++) begin
      mrs(m);
      for (int j = 0; j < 2 && !(m inside {3, 4, 7}); j++) begin
        x = xs();
        // Fast refreshes only in whole groups
        if (m < 3 || x[0])
          repeat (m % 4 == 1 ? 2 : m % 4 == 2 ? 4 : 1)
            refr(1'b1);
        else refr(1'b0);
      end
    end
    temp_i = 1'b1;
    mrs(1);
    mrs(0);
    temp_i = 1'b0;
    mrs(1);
    refr(1);
    srf();
    refr(1);
    refr(1);
    mrs(6);
    repeat (4) refr(1);
    srf();
    refr(1);
    srf();
    refr(0);
    end_of_test();
  end
endmodule : fine_granularity_refresh_mode_tb
